// file: iafe_frontend_ctrl.sv
// channel front end control: status, mux, gain, clocking, decimation
//
// Notes on behaviour
// - supply converter failure shows as fault flag one
// - fault flag stays set until status read
// - reading status clears the fault flag
// - per channel two bit input source select
// - per channel three bit gain, 1 to 128
// - precharge buffer on for gain 8 and up
// - modulator one sends carrier burst, zero none
// - received bitstream sinc decimated into samples
// - converter resonator kept synchronous to modulator clock
// - decimation supports rates up to 64 kSPS
// - programmable relative sampling phase between channels
// - offset and gain calibration applied to samples
// - modulator clock divider ratios 2, 4, 8, 12
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module iafe_frontend_ctrl
    import iafe_pkg::*;
#(
    parameter int OSR = 64
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // isolated side
    input wire logic supply_fault,
    input wire logic [NCH-1:0] mod_bit,
    output logic modulator_clock,
    output logic resonator_sync,
    output logic [NCH-1:0] ook_tx_en,
    output iafe_ch_ctrl_type [NCH-1:0] ch_ctrl,
    output logic [NCH-1:0] sample_valid,
    // interrupt
    output logic irq
);
    localparam int CW = $clog2(OSR);
    localparam logic [CW-1:0] LAST = CW'(OSR - 1);
    localparam logic signed [16:0] OSR17 = 17'(OSR);

    // offset removal then gain scaling, gain word 1.0 at GCAL_RST
    function automatic logic [15:0] calib(input logic signed [16:0] raw,
        input logic [15:0] ofs, input logic [15:0] gc);
        logic signed [17:0] d;
        logic signed [34:0] p;
        d = $signed({raw[16], raw}) - $signed({{2{ofs[15]}}, ofs});
        // widen both factors first, an 18 bit product would wrap
        p = 35'(d) * 35'($signed({1'b0, gc}));
        calib = p[GCAL_SHIFT +: 16];
    endfunction : calib

    ////////////////////////////////////////////////////////////////////////
    logic fault_flag_r, fault_flag_nxt;
    logic [1:0] src_r [NCH], src_nxt [NCH];
    logic [2:0] gain_r [NCH], gain_nxt [NCH];
    logic [15:0] ofs_r [NCH], ofs_nxt [NCH];
    logic [15:0] gcal_r [NCH], gcal_nxt [NCH];
    logic [15:0] data_r [NCH], data_nxt [NCH];
    logic [CW:0] acc_r [NCH], acc_nxt [NCH];
    logic [1:0] clkdiv_r, clkdiv_nxt;
    logic [CW-1:0] phase_r, phase_nxt, dec_r, dec_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [2:0] divcnt_r, divcnt_nxt;
    logic modclk_r, modclk_nxt;
    logic resync_r, resync_nxt;
    logic [NCH-1:0] ook_r, ook_nxt, valid_r, valid_nxt;
    logic addr_ok, rd_status, tick, win_end;
    logic [31:0] rd_val;
    logic [CW:0] ones;
    logic signed [16:0] raw;

    // address phase accepted; zero wait states, so hready is our own
    assign addr_ok = hsel & hready & htrans[1];
    assign rd_status = addr_ok & ~hwrite & (haddr[7:0] == OFS_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // read data mux, unmapped offsets read zero
    always_comb
    begin
        case (haddr[7:0])
            OFS_STATUS: rd_val = {31'h0, fault_flag_r};
            OFS_CH_CFG0: rd_val = {30'h0, src_r[0]};
            OFS_CH_CFG1: rd_val = {30'h0, src_r[1]};
            OFS_GAIN: rd_val = {25'h0, gain_r[1], 1'b0, gain_r[0]};
            OFS_CLOCK: rd_val = {30'h0, clkdiv_r};
            OFS_PHASE: rd_val = 32'(phase_r);
            OFS_OFFSET0: rd_val = {16'h0, ofs_r[0]};
            OFS_OFFSET1: rd_val = {16'h0, ofs_r[1]};
            OFS_GCAL0: rd_val = {16'h0, gcal_r[0]};
            OFS_GCAL1: rd_val = {16'h0, gcal_r[1]};
            OFS_DATA0: rd_val = {{16{data_r[0][15]}}, data_r[0]};
            OFS_DATA1: rd_val = {{16{data_r[1][15]}}, data_r[1]};
            OFS_IRQ_STAT: rd_val = 32'(irq_stat_r);
            OFS_IRQ_MASK: rd_val = 32'(irq_mask_r);
            default: rd_val = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of registers, divider and decimators
    always_comb
    begin
        ones = '0;
        raw = '0;
        win_end = 1'b0;
        src_nxt = src_r;
        gain_nxt = gain_r;
        ofs_nxt = ofs_r;
        gcal_nxt = gcal_r;
        data_nxt = data_r;
        acc_nxt = acc_r;
        clkdiv_nxt = clkdiv_r;
        phase_nxt = phase_r;
        irq_mask_nxt = irq_mask_r;
        wr_pend_nxt = addr_ok & hwrite;
        wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
        hrdata_nxt = (addr_ok & ~hwrite) ? rd_val : hrdata_r;
        // set wins over the clearing read
        fault_flag_nxt = supply_fault | (fault_flag_r & ~rd_status);
        irq_stat_nxt = irq_stat_r;
        if (wr_pend_r)
            case (wr_addr_r)
                OFS_CH_CFG0: src_nxt[0] = hwdata[1:0];
                OFS_CH_CFG1: src_nxt[1] = hwdata[1:0];
                OFS_GAIN:
                begin
                    gain_nxt[0] = hwdata[2:0];
                    gain_nxt[1] = hwdata[GAIN_CH1_LSB +: 3];
                end
                OFS_CLOCK: clkdiv_nxt = hwdata[1:0];
                OFS_PHASE: phase_nxt = hwdata[CW-1:0];
                OFS_OFFSET0: ofs_nxt[0] = hwdata[15:0];
                OFS_OFFSET1: ofs_nxt[1] = hwdata[15:0];
                OFS_GCAL0: gcal_nxt[0] = hwdata[15:0];
                OFS_GCAL1: gcal_nxt[1] = hwdata[15:0];
                OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~hwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: irq_mask_nxt = hwdata[IRQ_W-1:0];
                default: ;
            endcase
        // modulator clock, tolerant of a divider change mid count
        tick = 1'b0;
        divcnt_nxt = divcnt_r + 3'h1;
        modclk_nxt = modclk_r;
        if (divcnt_r >= iafe_div_half(clkdiv_r) - 3'h1)
        begin
            divcnt_nxt = 3'h0;
            modclk_nxt = ~modclk_r;
            tick = ~modclk_r;
        end
        resync_nxt = tick;
        ook_nxt = tick ? mod_bit : ook_r;
        dec_nxt = dec_r;
        valid_nxt = '0;
        if (tick)
        begin
            dec_nxt = (dec_r == LAST) ? '0 : dec_r + 1'b1;
            for (int c = 0; c < NCH; c++)
            begin
                // channel 1 window closes at the programmed phase
                win_end = (c == 0) ? (dec_r == LAST) : (dec_r == phase_r);
                ones = acc_r[c] + (CW+1)'(mod_bit[c]);
                raw = $signed(17'({ones, 1'b0})) - OSR17;
                acc_nxt[c] = win_end ? '0 : ones;
                if (win_end)
                begin
                    data_nxt[c] = calib(raw, ofs_r[c], gcal_r[c]);
                    valid_nxt[c] = 1'b1;
                end
            end
        end
        // events set sticky bits, set wins over write one to clear
        irq_stat_nxt[IRQ_FAULT] = irq_stat_nxt[IRQ_FAULT] | supply_fault;
        irq_stat_nxt[IRQ_RDY0 +: NCH] |= valid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // register stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_flag_r <= 1'b0;
            for (int c = 0; c < NCH; c++)
            begin
                src_r[c] <= SRC_RST;
                gain_r[c] <= GAIN_RST;
                ofs_r[c] <= 16'h0000;
                gcal_r[c] <= GCAL_RST;
                data_r[c] <= 16'h0000;
                acc_r[c] <= '0;
            end
            clkdiv_r <= CLKDIV_RST;
            phase_r <= '0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            divcnt_r <= 3'h0;
            modclk_r <= 1'b0;
            resync_r <= 1'b0;
            ook_r <= '0;
            dec_r <= '0;
            valid_r <= '0;
        end
        else
        begin
            fault_flag_r <= fault_flag_nxt;
            src_r <= src_nxt;
            gain_r <= gain_nxt;
            ofs_r <= ofs_nxt;
            gcal_r <= gcal_nxt;
            data_r <= data_nxt;
            acc_r <= acc_nxt;
            clkdiv_r <= clkdiv_nxt;
            phase_r <= phase_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
            divcnt_r <= divcnt_nxt;
            modclk_r <= modclk_nxt;
            resync_r <= resync_nxt;
            ook_r <= ook_nxt;
            dec_r <= dec_nxt;
            valid_r <= valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign modulator_clock = modclk_r;
    assign resonator_sync = resync_r;
    assign ook_tx_en = ook_r;
    assign sample_valid = valid_r;
    assign irq = |(irq_stat_r & irq_mask_r);
    // precharge buffer only helps the high gain, low signal ranges
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            ch_ctrl[c].src = iafe_src_type'(src_r[c]);
            ch_ctrl[c].gain = gain_r[c];
            ch_ctrl[c].precharge = (gain_r[c] >= PRECHARGE_MIN_GAIN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_fault_set;
        @(posedge clk) disable iff (rst) supply_fault |=> fault_flag_r;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault flag not set by supply failure");
    property p_fault_sticky;
        @(posedge clk) disable iff (rst)
            fault_flag_r && !rd_status |=> fault_flag_r;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault flag dropped without status read");
    property p_fault_clear;
        @(posedge clk) disable iff (rst)
            rd_status && !supply_fault |=> !fault_flag_r;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("status read did not clear fault flag");
    property p_read_old;
        @(posedge clk) disable iff (rst)
            rd_status && fault_flag_r |=> hrdata[0] && hreadyout;
    endproperty
    a_read_old: assert property (p_read_old)
        else $error("clearing read lost the fault flag");
    // gain codes 3 to 7 written as a gate, not as the compare above
    property p_precharge;
        @(posedge clk) disable iff (rst)
            ch_ctrl[0].precharge == (ch_ctrl[0].gain[2] | &ch_ctrl[0].gain[1:0])
            && ch_ctrl[1].precharge
            == (ch_ctrl[1].gain[2] | &ch_ctrl[1].gain[1:0]);
    endproperty
    a_precharge: assert property (p_precharge)
        else $error("precharge buffer does not match gain");
    property p_div2;
        @(posedge clk) disable iff (rst)
            $rose(modulator_clock) && clkdiv_r == 2'h0
            && $stable(clkdiv_r) |=> $fell(modulator_clock);
    endproperty
    a_div2: assert property (p_div2)
        else $error("modulator clock not divide by two");
    property p_ook;
        @(posedge clk) disable iff (rst)
            $rose(modulator_clock) |-> ook_tx_en == $past(mod_bit)
            ##1 $stable(ook_tx_en);
    endproperty
    a_ook: assert property (p_ook)
        else $error("carrier burst does not follow modulator bit");
    property p_resync;
        @(posedge clk) disable iff (rst)
            resonator_sync |-> $rose(modulator_clock) ##1 !resonator_sync;
    endproperty
    a_resync: assert property (p_resync)
        else $error("resonator sync off modulator clock edge");
    property p_win0;
        @(posedge clk) disable iff (rst)
            tick && dec_r == LAST |=> sample_valid[0]
            && irq_stat_r[IRQ_RDY0];
    endproperty
    a_win0: assert property (p_win0)
        else $error("channel 0 sample missing at window end");
    // phase compared as it stood at the tick, a write may land there
    property p_phase;
        @(posedge clk) disable iff (rst)
            sample_valid[1] |-> $past(tick) && $past(dec_r) == $past(phase_r);
    endproperty
    a_phase: assert property (p_phase)
        else $error("channel 1 sample off its programmed phase");
endmodule : iafe_frontend_ctrl

// file: iafe_mod_model.sv
// isolated side modulator model feeding the front end bit inputs
`timescale 1ns/1ps
module iafe_mod_model
    import iafe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the block
    input wire logic modulator_clock,
    // bit level wanted per channel
    input wire logic [NCH-1:0] pattern,
    // to the block
    output logic [NCH-1:0] mod_bit
);
    logic mclk_d;

    ////////////////////////////////////////////////////////////////////////
    // new bit launched on the falling modulator edge, stable at the rise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mclk_d <= 1'b0;
            mod_bit <= '0;
        end
        else
        begin
            mclk_d <= modulator_clock;
            if (mclk_d && !modulator_clock)
                mod_bit <= pattern;
        end
    end
endmodule : iafe_mod_model

// file: iafe_pkg.sv
// constants and types for the isolated front end control block
package iafe_pkg;
    localparam int NCH = 2;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CH_CFG0 = 8'h04;
    localparam logic [7:0] OFS_CH_CFG1 = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0C;
    localparam logic [7:0] OFS_CLOCK = 8'h10;
    localparam logic [7:0] OFS_PHASE = 8'h14;
    localparam logic [7:0] OFS_OFFSET0 = 8'h18;
    localparam logic [7:0] OFS_OFFSET1 = 8'h1C;
    localparam logic [7:0] OFS_GCAL0 = 8'h20;
    localparam logic [7:0] OFS_GCAL1 = 8'h24;
    localparam logic [7:0] OFS_DATA0 = 8'h28;
    localparam logic [7:0] OFS_DATA1 = 8'h2C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    // field positions
    localparam int GAIN_CH1_LSB = 4;
    localparam int IRQ_W = 3;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_RDY0 = 1;
    // reset values and thresholds
    localparam logic [15:0] GCAL_RST = 16'h8000;
    localparam int GCAL_SHIFT = 15;
    localparam logic [1:0] CLKDIV_RST = 2'h0;
    localparam logic [2:0] PRECHARGE_MIN_GAIN = 3'h3;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [2:0] GAIN_RST = 3'h0;

    typedef enum logic [1:0]
    {
        SRC_PINS = 2'h0,
        SRC_GND = 2'h1,
        SRC_TEST_POS = 2'h2,
        SRC_TEST_NEG = 2'h3
    } iafe_src_type;

    typedef struct packed
    {
        iafe_src_type src;
        logic [2:0] gain;
        logic precharge;
    } iafe_ch_ctrl_type;

    // half period of the modulator clock in main clocks: ratio 2,4,8,12
    function automatic logic [2:0] iafe_div_half(input logic [1:0] sel);
        unique case (sel)
            2'h0: iafe_div_half = 3'h1;
            2'h1: iafe_div_half = 3'h2;
            2'h2: iafe_div_half = 3'h4;
            2'h3: iafe_div_half = 3'h6;
        endcase
    endfunction : iafe_div_half
endpackage : iafe_pkg

// file: iafe_tb.sv
// self-checking bench for the isolated front end control block
`timescale 1ns/1ps
module testbench
    import iafe_pkg::*;
;
    localparam int OSR_SIM = 8;
    localparam int PH = 3;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, supply_fault;
    logic modulator_clock, resonator_sync, irq, mclk_d;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NCH-1:0] mod_bit, ook_tx_en, sample_valid, pattern;
    iafe_ch_ctrl_type [NCH-1:0] ch_ctrl;
    int miscompares, num_checks, cyc, p, rs;
    int ndiv[4] = '{2, 4, 8, 12};

    assign hready = hreadyout;

    iafe_frontend_ctrl #(.OSR(OSR_SIM)) dut (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .supply_fault(supply_fault),
        .mod_bit(mod_bit), .modulator_clock(modulator_clock),
        .resonator_sync(resonator_sync), .ook_tx_en(ook_tx_en),
        .ch_ctrl(ch_ctrl), .sample_valid(sample_valid), .irq(irq));

    iafe_mod_model mdl (.clk(clk), .rst(rst),
        .modulator_clock(modulator_clock), .pattern(pattern),
        .mod_bit(mod_bit));

    ////////////////////////////////////////////////////////////////////////
    // clock, and a ceiling on run length in case a wait never ends
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        mclk_d <= modulator_clock;
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            num_checks++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("ERROR at %0t: seen %h expected %h", $time, seen,
                    exp);
            end
        end
    endtask : chk

    // one ahb single transfer; waits on hready, never on a cycle count
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= {24'h000000, a};
            hwrite <= w;
            do @(posedge clk); while (hready !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            do @(posedge clk); while (hready !== 1'b1);
            r = hrdata;
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        begin
            xfer(1'b1, a, d, r);
            @(negedge clk);
        end
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        begin
            xfer(1'b0, a, 32'h00000000, r);
            chk(r, exp);
        end
    endtask : rdchk

    task automatic wait_sv(input int ch);
        begin
            do @(posedge clk); while (sample_valid[ch] !== 1'b1);
        end
    endtask : wait_sv

    task automatic wait_rise();
        begin
            do @(posedge clk);
            while (!(modulator_clock === 1'b1 && mclk_d === 1'b0));
        end
    endtask : wait_rise

    task automatic pulse_fault();
        begin
            @(posedge clk);
            supply_fault <= 1'b1;
            @(posedge clk);
            supply_fault <= 1'b0;
            @(negedge clk);
        end
    endtask : pulse_fault

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {hsel, hwrite, supply_fault, mclk_d} = '0;
        {haddr, hwdata, htrans, pattern, miscompares, num_checks, cyc} = '0;
        hsize = 3'h2;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place reads zero
        chk(32'(ch_ctrl), 32'h0);
        chk(32'(irq), 32'h0);
        chk(32'(hresp), 32'h0);
        rdchk(OFS_GCAL0, 32'h00008000);
        rdchk(OFS_CLOCK, 32'h0);
        rdchk(OFS_GAIN, 32'h0);
        rdchk(8'h3C, 32'h0);
        $display("test reset done");
        // latched fault: set, held past recovery, cleared by reading
        pulse_fault();
        repeat (10) @(posedge clk);
        rdchk(OFS_STATUS, 32'h1);
        rdchk(OFS_STATUS, 32'h0);
        @(posedge clk);
        supply_fault <= 1'b1;
        rdchk(OFS_STATUS, 32'h1);
        rdchk(OFS_STATUS, 32'h1);
        supply_fault <= 1'b0;
        rdchk(OFS_STATUS, 32'h1);
        rdchk(OFS_STATUS, 32'h0);
        $display("test fault done");
        // every source code on both channels
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CH_CFG0, 32'(s));
            wr(OFS_CH_CFG1, 32'(3 - s));
            chk(32'(ch_ctrl[0].src), 32'(s));
            chk(32'(ch_ctrl[1].src), 32'(3 - s));
        end
        rdchk(OFS_CH_CFG1, 32'h0);
        // every gain code, precharge from gain 8 up
        for (int g = 0; g < 8; g++)
        begin
            wr(OFS_GAIN, 32'(g) | (32'(7 - g) << GAIN_CH1_LSB));
            chk(32'(ch_ctrl[0].gain), 32'(g));
            chk(32'(ch_ctrl[1].gain), 32'(7 - g));
            chk(32'(ch_ctrl[0].precharge), 32'(g >= 3));
            chk(32'(ch_ctrl[1].precharge), 32'(7 - g >= 3));
        end
        rdchk(OFS_GAIN, 32'h00000007);
        $display("test mux and gain done");
        // divider ratios, one resonator pulse per modulator period
        for (int k = 3; k >= 0; k--)
        begin
            wr(OFS_CLOCK, 32'(k));
            repeat (2) wait_rise();
            p = 0;
            rs = 0;
            do
            begin
                @(posedge clk);
                p++;
                if (resonator_sync === 1'b1)
                    rs++;
            end
            while (!(modulator_clock === 1'b1 && mclk_d === 1'b0));
            chk(32'(p), 32'(ndiv[k]));
            chk(32'(rs), 32'h1);
        end
        $display("test clock done");
        // carrier follows bits; full-scale windows decimate to +/- osr
        pattern <= 2'b01;
        repeat (3) wait_rise();
        @(negedge clk);
        chk(32'(ook_tx_en), 32'h1);
        repeat (2) wait_sv(0);
        rdchk(OFS_DATA0, 32'(OSR_SIM));
        rdchk(OFS_DATA1, -32'(OSR_SIM));
        wr(OFS_OFFSET0, 32'h2);
        wr(OFS_GCAL0, 32'h4000);
        wr(OFS_GCAL1, 32'hC000);
        repeat (2) wait_sv(1);
        rdchk(OFS_DATA0, 32'((OSR_SIM - 2) / 2));
        rdchk(OFS_DATA1, -32'(OSR_SIM * 3 / 2));
        pattern <= 2'b10;
        repeat (3) wait_rise();
        @(negedge clk);
        chk(32'(ook_tx_en), 32'h2);
        $display("test stream done");
        // relative phase of channel 1 window end
        wr(OFS_PHASE, 32'(PH));
        repeat (2) wait_sv(0);
        p = 0;
        do
        begin
            @(posedge clk);
            p++;
        end
        while (sample_valid[1] !== 1'b1);
        chk(32'(p), 32'((PH + 1) * 2));
        $display("test phase done");
        // interrupts: ready and fault, masked and cleared
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h2);
        wait_sv(0);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        pulse_fault();
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
        $display("test irq done");
        final_report();
    end
endmodule : testbench
